/* common/cba_pkg.sv */
// Constants and types shared by the complement and decimal adjust datapath
package cba_pkg;

    // ==========================================================
    // Data widths and adjust constants
    localparam int          DATA_W      = 8;
    localparam logic [3:0]  NIB_MAX     = 4'h9;
    localparam logic [7:0]  ADJ_NONE    = 8'h00;
    localparam logic [7:0]  ADJ_LOW     = 8'h06;
    localparam logic [7:0]  ADJ_HIGH    = 8'h60;
    localparam logic [7:0]  ADJ_BOTH    = 8'h66;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  RST_DATA    = 8'h00;
    localparam logic        RST_FLAG    = 1'b0;

    // ==========================================================
    // Operation encoding
    typedef enum logic [1:0] {
        CBA_OP_NONE   = 2'h0,
        CBA_OP_INVERT = 2'h1,
        CBA_OP_FIXUP  = 2'h2
    } cba_op_t;

    // Result stage state, one-hot
    typedef enum logic [2:0] {
        CBA_ST_IDLE   = 3'h1,
        CBA_ST_INVERT = 3'h2,
        CBA_ST_FIXUP  = 3'h4
    } cba_state_t;

endpackage

/* dv/cba_datapath_properties.sv */
// Port-level checks for the complement and decimal adjust datapath
module cba_datapath_properties #(parameter int DATA_W = 8) (
    // All ports of the datapath, watched only
    input wire logic              mclk, rst_n, op_valid, half_carry_flag, carry_flag,
    input wire cba_pkg::cba_op_t  op_sel,
    input wire logic [DATA_W-1:0] mem_rdata, work_register, work_wdata, mem_wdata,
    input wire logic              work_we, mem_we, null_we, null_flag, carry_we,
    input wire logic              carry_flag_out, busy
);
    wire logic inv = op_valid && op_sel == cba_pkg::CBA_OP_INVERT;
    wire logic fix = op_valid && op_sel == cba_pkg::CBA_OP_FIXUP;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_inv_target: assert property (inv |=> work_we && null_we && !mem_we && !carry_we)
        else $error("invert wrote a wrong target");
    chk_inv_value: assert property (inv |=> work_wdata == ~$past(mem_rdata))
        else $error("invert value wrong");
    chk_null_value: assert property (inv |=> null_flag == (~$past(mem_rdata) == '0))
        else $error("null flag wrong");
    chk_fix_target: assert property (fix |=> mem_we && carry_we && !work_we && !null_we)
        else $error("adjust wrote a wrong target");
    chk_fix_addend: assert property (fix |=> (mem_wdata - $past(work_register)) inside {8'h00, 8'h06, 8'h60, 8'h66})
        else $error("adjust addend wrong");
    chk_fix_low: assert property (fix && (work_register[3:0] > 4'h9 || half_carry_flag) |=> (mem_wdata - $past(work_register)) inside {8'h06, 8'h66})
        else $error("low nibble not adjusted");
    chk_fix_high: assert property (fix && (work_register[7:4] > 4'h9 || carry_flag) |=> (mem_wdata - $past(work_register)) inside {8'h60, 8'h66})
        else $error("high nibble not adjusted");
    chk_fix_carry: assert property (fix && carry_flag |=> carry_flag_out)
        else $error("carry lost");
    chk_no_request: assert property (!inv && !fix |=> !work_we && !mem_we && !null_we && !carry_we)
        else $error("write without request");
endmodule
bind cba_datapath cba_datapath_properties #(.DATA_W(DATA_W)) u_chk (.mclk, .rst_n, .op_valid,
    .op_sel, .mem_rdata, .work_register, .half_carry_flag, .carry_flag, .work_we, .work_wdata,
    .mem_we, .mem_wdata, .null_we, .null_flag, .carry_we, .carry_flag_out, .busy);

/* dv/complement_and_bcd_adjust_tb_top.sv */
// Self-checking bench for the complement and decimal adjust datapath
module complement_and_bcd_adjust_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic             mclk, rst_n, op_valid, half_carry_flag, carry_flag;
    logic             work_we, mem_we, null_we, carry_we, null_flag, carry_flag_out, busy;
    logic [7:0]       mem_rdata, work_register, work_wdata, mem_wdata;
    cba_pkg::cba_op_t op_sel;
    int               err_count, compares;
    // Rows: op, memory byte, work reg, flags (2 half carry, 1 carry), result, flag
    logic [35:0] rows [10] = '{36'h1_ff_00_0_00_1, 36'h1_5a_00_0_a5_0, 36'h1_00_00_3_ff_0,
        36'h2_00_15_0_15_0, 36'h2_00_0c_0_12_0, 36'h2_00_a3_0_03_1, 36'h2_00_12_2_18_0,
        36'h2_00_12_1_72_1, 36'h2_00_bb_0_21_1, 36'h2_00_99_3_ff_1};
    cba_datapath i_dut (.mclk, .rst_n, .op_valid, .op_sel, .mem_rdata, .work_register,
        .half_carry_flag, .carry_flag, .work_we, .work_wdata, .mem_we, .mem_wdata, .null_we,
        .null_flag, .carry_we, .carry_flag_out, .busy);
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d of %0d compares", err_count, compares);
        if (err_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic run(input logic [35:0] r);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_sel <= cba_pkg::cba_op_t'(r[33:32]);
        {mem_rdata, work_register} <= r[31:16];
        {half_carry_flag, carry_flag} <= r[13:12];
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
        // Invert drives work and null strobes, adjust drives memory and carry
        chk("result", {(r[33:32] == 2'h1) ? 4'ha : 4'h5, r[11:4]},
            {work_we, mem_we, null_we, carry_we,
             (r[33:32] == 2'h1) ? work_wdata : mem_wdata});
        chk("busy", 12'h1, {11'h0, busy});
        chk("flag", {11'h0, r[0]}, {11'h0, (r[33:32] == 2'h1) ? null_flag : carry_flag_out});
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        err_count++;
        close_out();
    end
    initial begin
        {rst_n, op_valid, half_carry_flag, carry_flag, mem_rdata, work_register} = '0;
        op_sel = cba_pkg::CBA_OP_NONE;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk("reset", 12'h0, {work_we, mem_we, null_we, carry_we, mem_wdata});
        foreach (rows[k]) run(rows[k]);
        // Unused encoding must write nothing and leave the last result standing
        @(posedge mclk);
        op_valid <= 1'b1;
        op_sel <= cba_pkg::cba_op_t'(2'h3);
        {mem_rdata, work_register} <= 16'h00_00;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
        chk("refused", 12'h0ff, {work_we, mem_we, null_we, carry_we, mem_wdata});
        chk("idle", 12'h001, {10'h0, busy, carry_flag_out});
        @(posedge mclk);
        rst_n <= 1'b0;
        #1 chk("midreset", 12'h0, {work_we, mem_we, null_we, carry_we, mem_wdata});
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        run(rows[5]);
        run(rows[0]);
        close_out();
    end
endmodule

/* hw/cba_adjust.sv */
// Combinational decimal adjust of one byte after a BCD addition
module cba_adjust #(
    parameter int DATA_W = 8
) (
    // Operand and flags
    input  wire logic [DATA_W-1:0] work_in,
    input  wire logic              half_carry_flag,
    input  wire logic              carry_in,
    // Result
    output logic      [DATA_W-1:0] adj_out,
    output logic                   carry_out
);
    initial begin
        if (DATA_W != 8) $error("cba_adjust serves only 8-bit data");
    end

    logic          fix_lo;
    logic          fix_hi;
    logic [7:0]    addend;
    logic [8:0]    sum;

    always_comb begin
        fix_lo = (work_in[3:0] > cba_pkg::NIB_MAX) || half_carry_flag;
        fix_hi = (work_in[7:4] > cba_pkg::NIB_MAX) || carry_in;
        case ({fix_hi, fix_lo})
            2'h1:    addend = cba_pkg::ADJ_LOW;
            2'h2:    addend = cba_pkg::ADJ_HIGH;
            2'h3:    addend = cba_pkg::ADJ_BOTH;
            default: addend = cba_pkg::ADJ_NONE;
        endcase
        sum       = {1'b0, work_in} + {1'b0, addend};
        adj_out   = sum[7:0];
        // Carry stays set for chained additions, set again on overflow
        carry_out = carry_in || sum[8];
    end
endmodule

/* hw/cba_datapath.sv */
// Complement and decimal adjust datapath slice with registered results

// Behaviour
// - The invert operation flips every bit of the addressed memory byte.
// - The invert result goes only to the working register and only the null flag changes.
// - The invert operation never writes back to data memory.
// - Decimal adjust adds 6 to the low nibble when it exceeds 9 or half carry is set.
// - Decimal adjust adds 6 to the high nibble when it exceeds 9 or carry is set.
// - Decimal adjust adds exactly one of 00, 06, 60 or 66 hex to the working register.
// - Decimal adjust stores its result into data memory, not the working register.
// - Decimal adjust changes only the carry flag, set when carry was set or adding the adjust overflows eight bits.
module cba_datapath #(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Operation request, one-cycle strobe
    input  wire logic              op_valid,
    input  wire cba_pkg::cba_op_t  op_sel,
    // Operands
    input  wire logic [DATA_W-1:0] mem_rdata,
    input  wire logic [DATA_W-1:0] work_register,
    input  wire logic              half_carry_flag,
    input  wire logic              carry_flag,
    // Working register write
    output logic                   work_we,
    output logic      [DATA_W-1:0] work_wdata,
    // Data memory write
    output logic                   mem_we,
    output logic      [DATA_W-1:0] mem_wdata,
    // Flag writes
    output logic                   null_we,
    output logic                   null_flag,
    output logic                   carry_we,
    output logic                   carry_flag_out,
    // Status
    output logic                   busy
);
    initial begin
        if (DATA_W != 8) $error("cba_datapath serves only 8-bit data");
    end

    // ==========================================================
    // State
    typedef struct packed {
        cba_pkg::cba_state_t st;
        logic [DATA_W-1:0]   res;
        logic                flag;
    } cba_regs_t;

    cba_regs_t   r_q;
    cba_regs_t   r_d;
    logic [DATA_W-1:0] adj_res;
    logic        adj_carry;

    cba_adjust #(
        .DATA_W          (DATA_W)
    ) u_adjust (
        .work_in         (work_register),
        .half_carry_flag (half_carry_flag),
        .carry_in        (carry_flag),
        .adj_out         (adj_res),
        .carry_out       (adj_carry)
    );

    // ==========================================================
    // Next state
    always_comb begin
        r_d    = r_q;
        r_d.st = cba_pkg::CBA_ST_IDLE;
        if (op_valid) begin
            case (op_sel)
                cba_pkg::CBA_OP_INVERT: begin
                    r_d.st   = cba_pkg::CBA_ST_INVERT;
                    r_d.res  = ~mem_rdata;
                    r_d.flag = (~mem_rdata == '0);
                end
                cba_pkg::CBA_OP_FIXUP: begin
                    r_d.st   = cba_pkg::CBA_ST_FIXUP;
                    r_d.res  = adj_res;
                    r_d.flag = adj_carry;
                end
                default: r_d.st = cba_pkg::CBA_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_q.st   <= cba_pkg::CBA_ST_IDLE;
            r_q.res  <= cba_pkg::RST_DATA;
            r_q.flag <= cba_pkg::RST_FLAG;
        end else begin
            r_q <= r_d;
        end
    end

    // ==========================================================
    // Outputs; each operation strobes only its own destinations
    always_comb begin
        work_we  = (r_q.st == cba_pkg::CBA_ST_INVERT);
        null_we  = (r_q.st == cba_pkg::CBA_ST_INVERT);
        mem_we   = (r_q.st == cba_pkg::CBA_ST_FIXUP);
        carry_we = (r_q.st == cba_pkg::CBA_ST_FIXUP);
        busy     = (r_q.st != cba_pkg::CBA_ST_IDLE);
    end

    assign work_wdata     = r_q.res;
    assign mem_wdata      = r_q.res;
    assign null_flag      = r_q.flag;
    assign carry_flag_out = r_q.flag;
endmodule
